//--- motor_fault_pkg.sv
package motor_fault_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_STATUS     = 8'h00;
   localparam logic [7:0] OFS_MASK       = 8'h04;
   localparam logic [7:0] OFS_DETECT_THR = 8'h08;
   localparam logic [7:0] OFS_ABN_THR    = 8'h0C;
   localparam logic [7:0] OFS_BEMF_CONST = 8'h10;
   localparam logic [7:0] OFS_OVL_THR    = 8'h14;
   localparam logic [7:0] OFS_SPIKE_THR  = 8'h18;
   localparam logic [7:0] OFS_MISS_THR   = 8'h1C;
   localparam logic [7:0] OFS_BASE_CUR   = 8'h20;
   localparam logic [7:0] OFS_GAINS      = 8'h24;
   localparam logic [7:0] OFS_GAIN_USED  = 8'h28;
   localparam logic [7:0] OFS_STATE      = 8'h2C;
   // Status bit positions
   localparam int BIT_POS_DETECT = 0;
   localparam int BIT_POS_BEMF   = 1;
   localparam int BIT_POS_ABN    = 2;
   localparam int BIT_POS_OVL    = 3;
   localparam int BIT_POS_SPIKE  = 4;
   localparam int BIT_POS_MISS   = 5;
   localparam int NUM_FAULTS     = 6;
   // Reset values
   localparam logic [7:0]  RST_ABN_THR    = 8'h28;   // 40 percent
   localparam logic [15:0] RST_DETECT_THR = 16'h0100;
   localparam logic [15:0] RST_BEMF_CONST = 16'h0000;
   localparam logic [15:0] RST_OVL_THR    = 16'h0800;
   localparam logic [15:0] RST_SPIKE_THR  = 16'h0C00;
   localparam logic [7:0]  RST_MISS_THR   = 8'h05;
   localparam logic [15:0] RST_BASE_CUR   = 16'h1000;
   localparam logic [31:0] RST_GAINS      = 32'h0000_0000;
   localparam logic [31:0] AUTO_GAINS     = 32'h1010_1010;
   // Timing of the missing motor check
   localparam int CLK_MHZ        = 200;
   localparam int MISS_TIME_US   = 100;
   localparam int MISS_CYCLES    = MISS_TIME_US * CLK_MHZ;
endpackage : motor_fault_pkg

//--- motor_fault_monitor.sv
`timescale 1ns/1ps
module motor_fault_monitor #(
   parameter int MISS_CNT = motor_fault_pkg::MISS_CYCLES
) (
   input  wire logic        sys_clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        detectActive,
   input  wire logic        detectDone,
   input  wire logic        openLoopActive,
   input  wire logic        stallSeen,
   input  wire logic        runActive,
   input  wire logic [15:0] phaseCurrent,
   input  wire logic [15:0] backemfEstimate,
   input  wire logic [15:0] spikeCurrent,
   output logic [31:0]      gainsUsed,
   output logic             autoGains,
   output logic             faultAny,
   output logic             irq
);
   import motor_fault_pkg::*;

   // Status and configuration registers
   logic [NUM_FAULTS-1:0] status_r;
   logic [NUM_FAULTS-1:0] mask_r;
   logic [15:0]           detectThr_r;
   logic [7:0]            abnThr_r;
   logic [15:0]           bemfConst_r;
   logic [15:0]           ovlThr_r;
   logic [15:0]           spikeThr_r;
   logic [7:0]            missThr_r;
   logic [15:0]           baseCur_r;
   logic [31:0]           gains_r;
   // Fault plumbing
   logic [NUM_FAULTS-1:0] event_nxt;
   logic [NUM_FAULTS-1:0] clear_nxt;
   logic                  peakSeen_r;
   logic [31:0]           missCnt_r;
   // Bus decode
   logic                  wrEn;
   logic                  rdEn;
   logic                  addrOk;
   // Threshold products
   logic [31:0]           bemfScaled;
   logic [31:0]           bemfLimit;
   logic [31:0]           missScaled;
   logic [31:0]           missLimit;

   // Async inputs from the power stage, two flops each
   logic [15:0]           curS1_r;
   logic [15:0]           curS2_r;
   logic [15:0]           bemfS1_r;
   logic [15:0]           bemfS2_r;
   logic [15:0]           spkS1_r;
   logic [15:0]           spkS2_r;
   logic [4:0]            ctlS1_r;
   logic [4:0]            ctlS2_r;

   // Phase current synchroniser
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         curS1_r <= 16'h0000;
         curS2_r <= 16'h0000;
      end else begin
         curS1_r <= phaseCurrent;
         curS2_r <= curS1_r;
      end
   end

   // Back-EMF estimate synchroniser
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bemfS1_r <= 16'h0000;
         bemfS2_r <= 16'h0000;
      end else begin
         bemfS1_r <= backemfEstimate;
         bemfS2_r <= bemfS1_r;
      end
   end

   // Spike current synchroniser
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         spkS1_r <= 16'h0000;
         spkS2_r <= 16'h0000;
      end else begin
         spkS1_r <= spikeCurrent;
         spkS2_r <= spkS1_r;
      end
   end

   // Control level synchroniser
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctlS1_r <= 5'h00;
         ctlS2_r <= 5'h00;
      end else begin
         ctlS1_r <= {runActive, stallSeen, openLoopActive, detectDone, detectActive};
         ctlS2_r <= ctlS1_r;
      end
   end

   // Synchronised control levels
   logic                  detAct;
   logic                  detDone;
   logic                  olAct;
   logic                  stall;
   logic                  run;
   assign detAct  = ctlS2_r[0];
   assign detDone = ctlS2_r[1];
   assign olAct   = ctlS2_r[2];
   assign stall   = ctlS2_r[3];
   assign run     = ctlS2_r[4];

   // APB decode, zero wait states
   assign pready  = 1'b1;
   // Access phase strobes
   assign wrEn    = psel && penable && pwrite;
   assign rdEn    = psel && penable && !pwrite;

   // Address map decode
   always_comb begin
      unique case (paddr)
         OFS_STATUS, OFS_MASK, OFS_DETECT_THR, OFS_ABN_THR, OFS_BEMF_CONST,
         OFS_OVL_THR, OFS_SPIKE_THR, OFS_MISS_THR, OFS_BASE_CUR, OFS_GAINS,
         OFS_GAIN_USED, OFS_STATE: addrOk = 1'b1;
         default:                 addrOk = 1'b0;
      endcase
   end
   // Unmapped access answers with an error
   assign pslverr = psel && penable && !addrOk;

   // Back-EMF against percentage of constant
   assign bemfScaled = {16'h0000, bemfS2_r} * 32'h0000_0064;
   assign bemfLimit  = {16'h0000, bemfConst_r} * {24'h00_0000, abnThr_r};
   // Phase current against percentage of base current
   assign missScaled = {16'h0000, curS2_r} * 32'h0000_0064;
   assign missLimit  = {16'h0000, baseCur_r} * {24'h00_0000, missThr_r};

   // Peak current during position detect
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         peakSeen_r <= 1'b0;
      end else if (!detAct) begin
         peakSeen_r <= 1'b0;
      end else if (curS2_r >= detectThr_r) begin
         peakSeen_r <= 1'b1;
      end
   end

   // Low current run time counter
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         missCnt_r <= 32'h0000_0000;
      end else if (!run || missScaled >= missLimit) begin
         missCnt_r <= 32'h0000_0000;
      end else if (missCnt_r < 32'(MISS_CNT)) begin
         missCnt_r <= missCnt_r + 32'h0000_0001;
      end
   end

   // Fault events
   always_comb begin
      event_nxt = '0;
      event_nxt[BIT_POS_DETECT] = detAct && detDone && !peakSeen_r
                                  && curS2_r < detectThr_r;
      event_nxt[BIT_POS_BEMF]   = olAct && stall;
      event_nxt[BIT_POS_ABN]    = run && bemfConst_r != 16'h0000
                                  && bemfScaled < bemfLimit;
      event_nxt[BIT_POS_OVL]    = run && curS2_r > ovlThr_r;
      event_nxt[BIT_POS_SPIKE]  = spkS2_r > spikeThr_r;
      event_nxt[BIT_POS_MISS]   = missCnt_r == 32'(MISS_CNT);
   end

   assign clear_nxt = (wrEn && paddr == OFS_STATUS) ? pwdata[NUM_FAULTS-1:0] : '0;

   // Sticky status, one flop per fault, set wins over clear
   generate
      for (genvar i = 0; i < NUM_FAULTS; i++) begin : g_status
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               status_r[i] <= 1'b0;
            end else if (event_nxt[i]) begin
               status_r[i] <= 1'b1;
            end else if (clear_nxt[i]) begin
               status_r[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // Interrupt mask
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         mask_r <= '0;
      end else if (wrEn && paddr == OFS_MASK) begin
         mask_r <= pwdata[NUM_FAULTS-1:0];
      end
   end

   // Position detect current threshold
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         detectThr_r <= RST_DETECT_THR;
      end else if (wrEn && paddr == OFS_DETECT_THR) begin
         detectThr_r <= pwdata[15:0];
      end
   end

   // Abnormal back-EMF percentage
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         abnThr_r <= RST_ABN_THR;
      end else if (wrEn && paddr == OFS_ABN_THR) begin
         abnThr_r <= pwdata[7:0];
      end
   end

   // Back-EMF constant
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bemfConst_r <= RST_BEMF_CONST;
      end else if (wrEn && paddr == OFS_BEMF_CONST) begin
         bemfConst_r <= pwdata[15:0];
      end
   end

   // Overload current threshold
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ovlThr_r <= RST_OVL_THR;
      end else if (wrEn && paddr == OFS_OVL_THR) begin
         ovlThr_r <= pwdata[15:0];
      end
   end

   // Spike current threshold
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         spikeThr_r <= RST_SPIKE_THR;
      end else if (wrEn && paddr == OFS_SPIKE_THR) begin
         spikeThr_r <= pwdata[15:0];
      end
   end

   // Missing motor percentage
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         missThr_r <= RST_MISS_THR;
      end else if (wrEn && paddr == OFS_MISS_THR) begin
         missThr_r <= pwdata[7:0];
      end
   end

   // Base current
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         baseCur_r <= RST_BASE_CUR;
      end else if (wrEn && paddr == OFS_BASE_CUR) begin
         baseCur_r <= pwdata[15:0];
      end
   end

   // Programmed controller gains
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gains_r <= RST_GAINS;
      end else if (wrEn && paddr == OFS_GAINS) begin
         gains_r <= pwdata;
      end
   end

   // Automatic gain flag
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         autoGains <= 1'b1;
      end else begin
         autoGains <= gains_r == 32'h0000_0000;
      end
   end

   // Gains handed to the control loops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gainsUsed <= AUTO_GAINS;
      end else begin
         gainsUsed <= (gains_r == 32'h0000_0000) ? AUTO_GAINS : gains_r;
      end
   end

   // Interrupt, follows the status value being written
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((status_r & ~clear_nxt) | event_nxt) & mask_r);
      end
   end

   // Any fault summary
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         faultAny <= 1'b0;
      end else begin
         faultAny <= |((status_r & ~clear_nxt) | event_nxt);
      end
   end

   // Read data
   always_comb begin
      prdata = 32'h0000_0000;
      if (rdEn) begin
         unique case (paddr)
            OFS_STATUS:     prdata = {26'h000_0000, status_r};
            OFS_MASK:       prdata = {26'h000_0000, mask_r};
            OFS_DETECT_THR: prdata = {16'h0000, detectThr_r};
            OFS_ABN_THR:    prdata = {24'h00_0000, abnThr_r};
            OFS_BEMF_CONST: prdata = {16'h0000, bemfConst_r};
            OFS_OVL_THR:    prdata = {16'h0000, ovlThr_r};
            OFS_SPIKE_THR:  prdata = {16'h0000, spikeThr_r};
            OFS_MISS_THR:   prdata = {24'h00_0000, missThr_r};
            OFS_BASE_CUR:   prdata = {16'h0000, baseCur_r};
            OFS_GAINS:      prdata = gains_r;
            OFS_GAIN_USED:  prdata = gainsUsed;
            OFS_STATE:      prdata = {27'h000_0000, ctlS2_r};
            default:        prdata = 32'h0000_0000;
         endcase
      end
   end
endmodule : motor_fault_monitor

//--- motor_fault_monitor_checker.sv
`timescale 1ns/1ps
module motor_fault_monitor_checker (
   input wire logic        sys_clk,
   input wire logic        rstn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        openLoopActive,
   input wire logic        stallSeen,
   input wire logic        runActive,
   input wire logic [15:0] phaseCurrent,
   input wire logic [15:0] spikeCurrent,
   input wire logic [31:0] gainsUsed,
   input wire logic        autoGains,
   input wire logic        faultAny,
   input wire logic        irq
);
   import motor_fault_pkg::*;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic acc, wr0, wrG;
   // Decoded bus accesses
   assign acc = psel && penable;
   assign wr0 = acc && pwrite && paddr == OFS_STATUS;
   assign wrG = acc && pwrite && paddr == OFS_GAINS;
   property p_rdy; pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready low");
   property p_err; acc && paddr > OFS_STATE |-> pslverr; endproperty
   a_err: assert property (p_err) else $error("no slave error");
   property p_irq; irq |-> faultAny; endproperty
   a_irq: assert property (p_irq) else $error("irq without fault");
   property p_latch; $fell(faultAny) |-> $past(wr0) || $past(wr0, 2); endproperty
   a_latch: assert property (p_latch) else $error("fault dropped");
   property p_spike; spikeCurrent == 16'hFFFF [*3] |-> ##[0:2] faultAny; endproperty
   a_spike: assert property (p_spike) else $error("spike missed");
   property p_stall; openLoopActive && stallSeen [*3] |-> ##[0:2] faultAny; endproperty
   a_stall: assert property (p_stall) else $error("stall missed");
   property p_ovl; runActive && phaseCurrent == 16'hFFFF [*3] |-> ##[0:2] faultAny; endproperty
   a_ovl: assert property (p_ovl) else $error("overload missed");
   property p_auto; wrG && pwdata == 0 |-> ##[1:3] autoGains && gainsUsed == AUTO_GAINS; endproperty
   a_auto: assert property (p_auto) else $error("auto gains missing");
   property p_prog; wrG && pwdata != 0 |-> ##[1:3] !autoGains; endproperty
   a_prog: assert property (p_prog) else $error("auto gains kept");
endmodule : motor_fault_monitor_checker
bind motor_fault_monitor motor_fault_monitor_checker u_chk (.*);

//--- motor_model.sv
`timescale 1ns/1ps
module motor_model (
   input wire logic [2:0] mode,
   output logic           detectActive,
   output logic           detectDone,
   output logic           openLoopActive,
   output logic           stallSeen,
   output logic           runActive,
   output logic [15:0]    phaseCurrent,
   output logic [15:0]    backemfEstimate,
   output logic [15:0]    spikeCurrent
);
   // Modes: 1 no motor at detect, 2 stall, 3 run, 4 weak emf, 5 overload, 6 spike, 7 open phases
   assign detectActive    = mode == 3'd1;
   assign detectDone      = mode == 3'd1;
   assign openLoopActive  = mode == 3'd2;
   assign stallSeen       = mode == 3'd2;
   assign runActive       = mode >= 3'd3 && mode != 3'd6;
   assign phaseCurrent    = mode == 3'd5 ? 16'hFFFF : (runActive && mode != 3'd7 ? 16'h0400 : 16'h0000);
   assign backemfEstimate = mode == 3'd4 ? 16'h0001 : 16'h0400;
   assign spikeCurrent    = mode == 3'd6 ? 16'hFFFF : 16'h0000;
endmodule : motor_model

//--- testbench.sv
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin miscompares++; $display("[FAIL] %0t %s", $time, m); end end
module testbench;
   import motor_fault_pkg::*;
   logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, errCap;
   logic autoGains, faultAny, irq, detectActive, detectDone, openLoopActive, stallSeen, runActive;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, gainsUsed, rdCap;
   logic [15:0] phaseCurrent, backemfEstimate, spikeCurrent;
   logic [2:0]  mode = 3'd0;
   int miscompares = 0, n_checks = 0, cyc = 0;
   motor_fault_monitor #(.MISS_CNT(16)) u_dut (.*);
   motor_model u_motor (.*);
   always #2.5 sys_clk = ~sys_clk;
   // Answer capture and hang guard
   always @(posedge sys_clk) begin
      rdCap <= prdata;
      errCap <= pslverr;
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge sys_clk);
      penable <= 1;
      @(posedge sys_clk);
      while (pready !== 1'b1) @(posedge sys_clk);
      {psel, penable} <= 2'b00;
      #1;
   endtask : apb
   task drive(input logic [2:0] m, input int n);
      @(posedge sys_clk);
      mode <= m;
      repeat (n) @(posedge sys_clk);
      mode <= 3'd3;
      repeat (3) @(negedge sys_clk);
   endtask : drive
   task t_reset;
      apb(0, OFS_ABN_THR, 0);
      `CHK(rdCap, 32'h0000_0028, "abn thr reset")
      `CHK({autoGains, gainsUsed}, {1'b1, AUTO_GAINS}, "reset gains")
      $display("t_reset done");
   endtask : t_reset
   task t_gains;
      apb(1, OFS_GAINS, 32'h0000_0100);
      apb(1, OFS_GAIN_USED, 32'h0000_0000);
      apb(0, OFS_GAIN_USED, 0);
      `CHK({autoGains, rdCap}, {1'b0, 32'h0000_0100}, "one gain set")
      apb(1, OFS_GAINS, 32'h0000_0000);
      repeat (3) @(negedge sys_clk);
      `CHK({autoGains, gainsUsed}, {1'b1, AUTO_GAINS}, "all zero")
      $display("t_gains done");
   endtask : t_gains
   task t_mask;
      apb(1, OFS_MASK, 32'h0000_0000);
      drive(3'd6, 6);
      `CHK({faultAny, irq}, 2'b10, "masked")
      apb(1, OFS_MASK, 32'h0000_0010);
      repeat (3) @(negedge sys_clk);
      `CHK(irq, 1'b1, "unmasked")
      apb(1, OFS_STATUS, 32'h0000_0010);
      repeat (3) @(negedge sys_clk);
      `CHK({faultAny, irq}, 2'b00, "cleared")
      $display("t_mask done");
   endtask : t_mask
   task t_faults;
      logic [2:0] md[6] = '{3'd1, 3'd2, 3'd4, 3'd5, 3'd6, 3'd7};
      apb(1, OFS_BEMF_CONST, 32'h0000_0400);
      apb(1, OFS_MASK, 32'h0000_003F);
      for (int i = 0; i < 6; i++) begin
         drive(md[i], 24);
         apb(0, OFS_STATUS, 0);
         `CHK({irq, rdCap[5:0]}, {1'b1, 6'h01 << i}, "fault bit")
         apb(1, OFS_STATUS, 32'h0000_003F);
         apb(0, OFS_STATUS, 0);
         `CHK({faultAny, rdCap[5:0]}, 7'h00, "status clear")
      end
      $display("t_faults done");
   endtask : t_faults
   task t_bus;
      apb(0, 8'h40, 0);
      `CHK({errCap, rdCap}, {1'b1, 32'h0000_0000}, "unmapped")
      apb(1, OFS_ABN_THR, 32'h0000_000A);
      apb(0, OFS_ABN_THR, 0);
      `CHK(rdCap, 32'h0000_000A, "abn thr ten")
      apb(1, OFS_MISS_THR, 32'h0000_0001);
      apb(0, OFS_MISS_THR, 0);
      `CHK(rdCap, 32'h0000_0001, "miss thr low")
      apb(0, OFS_STATE, 0);
      `CHK(rdCap, 32'h0000_0010, "run state")
      $display("t_bus done");
   endtask : t_bus
   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      rstn <= 1;
      t_reset();
      t_gains();
      t_mask();
      t_faults();
      t_bus();
      report_and_stop();
   end
endmodule : testbench
